// [sdom_regs.svh]
// Purpose: register offsets, field positions and reset values of the status output mapper
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: definitions only
`ifndef SDOM_REGS_SVH
`define SDOM_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define SDOM_OFF_OSEL_LO 12'h000
`define SDOM_OFF_OSEL_HI 12'h004
`define SDOM_OFF_OPOL 12'h008
`define SDOM_OFF_ISEL 12'h00c
`define SDOM_OFF_IPOL 12'h010
`define SDOM_OFF_STATE 12'h014
`define SDOM_OFF_IRQ_STAT 12'h018
`define SDOM_OFF_IRQ_MASK 12'h01c

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SDOM_SEL_W 5
`define SDOM_SEL_STRIDE 8
`define SDOM_ISEL_W 2
`define SDOM_OSEL_RST 32'h0000_0000
`define SDOM_OPOL_RST 8'hff
`define SDOM_ISEL_RST 16'h0000
`define SDOM_IPOL_RST 8'h00
`define SDOM_IRQ_MASK_RST 2'h0
`define SDOM_IRQ_SPAN_BIT 0
`define SDOM_IRQ_ZERO_BIT 1

`endif

// [sdom_pkg.sv]
// Purpose: types of the status output mapper
// Assumes: nothing
// Notes: condition codes are the output selection values
package sdom_pkg;

  typedef enum logic [4:0] {
    SDOM_COND_DISABLED = 5'h00,
    SDOM_COND_HV_FAULT = 5'h01,
    SDOM_COND_PSU_FAULT = 5'h02,
    SDOM_COND_REF_FAULT = 5'h03,
    SDOM_COND_CONVERTER_FAULT = 5'h04,
    SDOM_COND_LAMP_FAULT = 5'h05,
    SDOM_COND_FLOW_FAULT = 5'h06,
    SDOM_COND_CELL_HEAT_FAULT = 5'h07,
    SDOM_COND_FLOW_HEAT_FAULT = 5'h08,
    SDOM_COND_LAMP_HEAT_FAULT = 5'h09,
    SDOM_COND_CHASSIS_FAULT = 5'h0a,
    SDOM_COND_COOLER_FAULT = 5'h0b,
    SDOM_COND_USB_ABSENT = 5'h0c,
    SDOM_COND_BACKGROUND = 5'h0d,
    SDOM_COND_SPAN = 5'h0e,
    SDOM_COND_ZERO = 5'h0f,
    SDOM_COND_SYSTEM_FAULT = 5'h10,
    SDOM_COND_MAINTENANCE = 5'h11,
    SDOM_COND_OVERRANGE_CH0 = 5'h12,
    SDOM_COND_OVERRANGE_CH1 = 5'h13,
    SDOM_COND_OVERRANGE_CH2 = 5'h14
  } sdom_cond_type;

  typedef enum logic [1:0] {
    SDOM_IN_DISABLED = 2'h0,
    SDOM_IN_DO_SPAN = 2'h1,
    SDOM_IN_DO_ZERO = 2'h2
  } sdom_in_action_type;

  typedef enum logic [1:0] {
    SDOM_CAL_MEASURE = 2'h0,
    SDOM_CAL_SPAN = 2'h1,
    SDOM_CAL_ZERO = 2'h2
  } sdom_cal_mode_type;

  typedef enum logic [2:0] {
    SDOM_BUS_IDLE = 3'b001,
    SDOM_BUS_WRITE = 3'b010,
    SDOM_BUS_READ = 3'b100
  } sdom_bus_state_type;

endpackage

// [sdom_mapper.sv]
// Purpose: maps fault, state and over-range flags onto eight status outputs; control inputs
// Assumes: one 100 MHz clock, AHB-Lite register access, flags from the same clock domain
// Notes: control input pins are synchronised through two flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "sdom_regs.svh"

module sdom_mapper #(
  parameter int OUTPUTS = 8,
  parameter int INPUTS = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [10:0] fault_flags_in,
  input wire logic usb_absent_in,
  input wire logic background_in,
  input wire logic span_check_in,
  input wire logic zero_check_in,
  input wire logic maintenance_in,
  input wire logic [2:0] analog_out_overrange_in,
  input wire logic [INPUTS-1:0] control_input_n_in,
  output logic [OUTPUTS-1:0] status_out,
  output logic [1:0] cal_mode_out,
  output logic irq_out
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] osel_lo;
  logic [31:0] osel_hi;
  logic [OUTPUTS-1:0] opol;
  logic [2*INPUTS-1:0] isel;
  logic [INPUTS-1:0] ipol;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [11:0] addr_q;
  logic [1:0] cal_mode;
  logic [OUTPUTS-1:0] status_q;
  sdom_pkg::sdom_bus_state_type bus_state;

  logic [31:0] next_osel_lo;
  logic [31:0] next_osel_hi;
  logic [OUTPUTS-1:0] next_opol;
  logic [2*INPUTS-1:0] next_isel;
  logic [INPUTS-1:0] next_ipol;
  logic [1:0] next_irq_stat;
  logic [1:0] next_irq_mask;
  logic [11:0] next_addr_q;
  logic [1:0] next_cal_mode;
  logic [OUTPUTS-1:0] next_status;
  sdom_pkg::sdom_bus_state_type next_bus_state;
  logic [31:0] next_rdata;
  logic [31:0] rdata_q;

  // ----------------------------------------
  // condition vector
  // ----------------------------------------
  logic [31:0] cond_vec;
  always_comb begin
    cond_vec = 32'h0000_0000;
    cond_vec[sdom_pkg::SDOM_COND_HV_FAULT +: 11] = fault_flags_in;
    cond_vec[sdom_pkg::SDOM_COND_USB_ABSENT] = usb_absent_in;
    cond_vec[sdom_pkg::SDOM_COND_BACKGROUND] = background_in;
    cond_vec[sdom_pkg::SDOM_COND_SPAN] = span_check_in;
    cond_vec[sdom_pkg::SDOM_COND_ZERO] = zero_check_in;
    cond_vec[sdom_pkg::SDOM_COND_SYSTEM_FAULT] = |fault_flags_in;
    cond_vec[sdom_pkg::SDOM_COND_MAINTENANCE] = maintenance_in;
    cond_vec[sdom_pkg::SDOM_COND_OVERRANGE_CH0 +: 3] = analog_out_overrange_in;
  end

  // ----------------------------------------
  // output mapping
  // ----------------------------------------
  logic [63:0] osel_all;
  assign osel_all = {osel_hi, osel_lo};
  genvar g;
  generate
    for (g = 0; g < OUTPUTS; g++) begin : g_out
      logic [4:0] sel;
      logic hit;
      assign sel = osel_all[g*`SDOM_SEL_STRIDE +: `SDOM_SEL_W];
      // code 0 is the disabled slot, always zero in cond_vec
      assign hit = (sel != 5'h00) && cond_vec[sel];
      assign next_status[g] = opol[g] ? hit : !hit;
    end
  endgenerate

  // ----------------------------------------
  // control inputs
  // ----------------------------------------
  logic [INPUTS-1:0] ci_meta;
  logic [INPUTS-1:0] ci_sync;
  logic [INPUTS-1:0] ci_act_q;
  logic [INPUTS-1:0] ci_act;
  logic [INPUTS-1:0] span_req;
  logic [INPUTS-1:0] zero_req;
  generate
    for (g = 0; g < INPUTS; g++) begin : g_in
      // pin at high level reads 1; active-low inputs invert
      assign ci_act[g] = ipol[g] ? ci_sync[g] : !ci_sync[g];
      assign span_req[g] = ci_act[g] && !ci_act_q[g]
        && (isel[2*g +: 2] == sdom_pkg::SDOM_IN_DO_SPAN);
      assign zero_req[g] = ci_act[g] && !ci_act_q[g]
        && (isel[2*g +: 2] == sdom_pkg::SDOM_IN_DO_ZERO);
    end
  endgenerate

  // ----------------------------------------
  // bus and register next state
  // ----------------------------------------
  logic take;
  logic stat_read;
  assign take = hsel_in && hready_in && htrans_in[1];
  assign stat_read = (bus_state == sdom_pkg::SDOM_BUS_READ)
    && (addr_q == `SDOM_OFF_IRQ_STAT);

  always_comb begin
    next_osel_lo = osel_lo;
    next_osel_hi = osel_hi;
    next_opol = opol;
    next_isel = isel;
    next_ipol = ipol;
    next_irq_mask = irq_mask;
    next_addr_q = addr_q;
    next_rdata = 32'h0000_0000;
    next_bus_state = sdom_pkg::SDOM_BUS_IDLE;
    case (bus_state)
      sdom_pkg::SDOM_BUS_WRITE: begin
        case (addr_q)
          `SDOM_OFF_OSEL_LO: next_osel_lo = hwdata_in;
          `SDOM_OFF_OSEL_HI: next_osel_hi = hwdata_in;
          `SDOM_OFF_OPOL: next_opol = hwdata_in[OUTPUTS-1:0];
          `SDOM_OFF_ISEL: next_isel = hwdata_in[2*INPUTS-1:0];
          `SDOM_OFF_IPOL: next_ipol = hwdata_in[INPUTS-1:0];
          `SDOM_OFF_IRQ_MASK: next_irq_mask = hwdata_in[1:0];
          default: begin
          end
        endcase
      end
      sdom_pkg::SDOM_BUS_READ: begin
      end
      sdom_pkg::SDOM_BUS_IDLE: begin
      end
      default: begin
      end
    endcase
    if (take) begin
      next_addr_q = {haddr_in[11:2], 2'b00};
      next_bus_state = hwrite_in ? sdom_pkg::SDOM_BUS_WRITE : sdom_pkg::SDOM_BUS_READ;
      case ({haddr_in[11:2], 2'b00})
        `SDOM_OFF_OSEL_LO: next_rdata = osel_lo;
        `SDOM_OFF_OSEL_HI: next_rdata = osel_hi;
        `SDOM_OFF_OPOL: next_rdata = {24'h000000, opol};
        `SDOM_OFF_ISEL: next_rdata = {16'h0000, isel};
        `SDOM_OFF_IPOL: next_rdata = {24'h000000, ipol};
        `SDOM_OFF_STATE: next_rdata = {14'h0000, ci_act, status_q, cal_mode};
        `SDOM_OFF_IRQ_STAT: next_rdata = {30'h00000000, irq_stat};
        `SDOM_OFF_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // calibration mode and interrupt status
  // ----------------------------------------
  logic state_wr;
  assign state_wr = (bus_state == sdom_pkg::SDOM_BUS_WRITE)
    && (addr_q == `SDOM_OFF_STATE);

  always_comb begin
    next_cal_mode = cal_mode;
    // code 3 names no mode, so such a write is dropped
    if (state_wr && (hwdata_in[1:0] != 2'h3)) begin
      next_cal_mode = hwdata_in[1:0];
    end
    // a request in the same cycle as a state write wins
    // zero request wins over span when both arrive together
    if (|span_req) begin
      next_cal_mode = sdom_pkg::SDOM_CAL_SPAN;
    end
    if (|zero_req) begin
      next_cal_mode = sdom_pkg::SDOM_CAL_ZERO;
    end
    // read clears, but an event in the same cycle still sets
    next_irq_stat = stat_read ? 2'b00 : irq_stat;
    next_irq_stat[`SDOM_IRQ_SPAN_BIT] = next_irq_stat[`SDOM_IRQ_SPAN_BIT] | (|span_req);
    next_irq_stat[`SDOM_IRQ_ZERO_BIT] = next_irq_stat[`SDOM_IRQ_ZERO_BIT] | (|zero_req);
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cal_mode <= sdom_pkg::SDOM_CAL_MEASURE;
      irq_stat <= 2'h0;
    end else begin
      cal_mode <= next_cal_mode;
      irq_stat <= next_irq_stat;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      osel_lo <= `SDOM_OSEL_RST;
      osel_hi <= `SDOM_OSEL_RST;
      opol <= `SDOM_OPOL_RST;
      isel <= `SDOM_ISEL_RST;
      ipol <= `SDOM_IPOL_RST;
      irq_mask <= `SDOM_IRQ_MASK_RST;
      addr_q <= 12'h000;
      rdata_q <= 32'h0000_0000;
      bus_state <= sdom_pkg::SDOM_BUS_IDLE;
    end else begin
      osel_lo <= next_osel_lo;
      osel_hi <= next_osel_hi;
      opol <= next_opol;
      isel <= next_isel;
      ipol <= next_ipol;
      irq_mask <= next_irq_mask;
      addr_q <= next_addr_q;
      rdata_q <= next_rdata;
      bus_state <= next_bus_state;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  // registered so the pins never glitch while a selection changes
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= {OUTPUTS{1'b0}};
    end else begin
      status_q <= next_status;
    end
  end

  // ----------------------------------------
  // control input synchroniser
  // ----------------------------------------
  // only ci_sync reads ci_meta; pins idle high, so both start at one
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ci_meta <= {INPUTS{1'b1}};
      ci_sync <= {INPUTS{1'b1}};
      ci_act_q <= {INPUTS{1'b0}};
    end else begin
      ci_meta <= control_input_n_in;
      ci_sync <= ci_meta;
      ci_act_q <= ci_act;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero-wait slave: every transfer answers at the first data-phase edge
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_q;
  assign status_out = status_q;
  assign cal_mode_out = cal_mode;
  assign irq_out = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

// [sdom_ext_equip.sv]
// Purpose: far-side calibrator model driving the control inputs
// Assumes: request lines from the bench change right after a rising edge
// Notes: unused pins sit at the 5 V pull-up level
`timescale 1ns/1ps
`default_nettype none
module sdom_ext_equip (
  input wire logic span_req_in,
  input wire logic zero_req_in,
  output logic [7:0] pins_out
);
  // a request pulls its pin to 0 V, otherwise the pull-up holds it high
  always_comb begin
    pins_out = {6'h3f, ~zero_req_in, ~span_req_in};
  end
endmodule
`default_nettype wire

// [sdom_mapper_checker.sv]
// Purpose: port-level assertions of the status output mapper
// Assumes: single clock domain
// Notes: counters bound how long an output may lag its cause
`timescale 1ns/1ps
`default_nettype none
module sdom_mapper_checker #(
  parameter int OUTPUTS = 8,
  parameter int INPUTS = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [10:0] fault_flags_in,
  input wire logic usb_absent_in,
  input wire logic background_in,
  input wire logic span_check_in,
  input wire logic zero_check_in,
  input wire logic maintenance_in,
  input wire logic [2:0] analog_out_overrange_in,
  input wire logic [INPUTS-1:0] control_input_n_in,
  input wire logic [OUTPUTS-1:0] status_out,
  input wire logic [1:0] cal_mode_out,
  input wire logic irq_out
);
  logic tk, wtk;
  logic [19:0] cnd, cnd_d;
  logic [INPUTS-1:0] ctl_d;
  logic [3:0] q_st, q_ct, q_bus;
  assign tk = hsel_in && hready_in && htrans_in[1];
  assign wtk = tk && hwrite_in;
  assign cnd = {fault_flags_in, usb_absent_in, background_in, span_check_in,
    zero_check_in, maintenance_in, analog_out_overrange_in};
  // cycles since the last possible cause, saturating
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnd_d <= '0;
      ctl_d <= '1;
      q_st <= 4'h0;
      q_ct <= 4'h0;
      q_bus <= 4'h0;
    end else begin
      cnd_d <= cnd;
      ctl_d <= control_input_n_in;
      q_st <= (wtk || cnd != cnd_d) ? 4'h0 : q_st + {3'h0, q_st != 4'hf};
      q_ct <= (wtk || control_input_n_in != ctl_d) ? 4'h0 : q_ct + {3'h0, q_ct != 4'hf};
      q_bus <= tk ? 4'h0 : q_bus + {3'h0, q_bus != 4'hf};
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rdy; hreadyout_out; endproperty
  a_rdy: assert property (p_rdy) else $error("hreadyout low");
  property p_okay; !hresp_out; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_stat; $changed(status_out) |-> q_st <= 4'h4; endproperty
  a_stat: assert property (p_stat) else $error("status moved without cause");
  property p_cal; $changed(cal_mode_out) |-> q_ct <= 4'h6; endproperty
  a_cal: assert property (p_cal) else $error("cal mode moved without cause");
  property p_cal_ok; cal_mode_out != 2'h3; endproperty
  a_cal_ok: assert property (p_cal_ok) else $error("cal mode illegal");
  property p_irq_up; $rose(irq_out) |-> q_ct <= 4'h6; endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
  property p_irq_dn; $fell(irq_out) |-> q_bus <= 4'h3; endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell without access");
  property p_unm; tk && !hwrite_in && haddr_in == 32'h20 |=> hrdata_out == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_stat: cover property ($changed(status_out));
  c_cal: cover property ($changed(cal_mode_out));
  c_irq: cover property ($fell(irq_out));
endmodule
bind sdom_mapper sdom_mapper_checker #(.OUTPUTS(OUTPUTS), .INPUTS(INPUTS)) u_chk (.mclk_in,
  .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out,
  .hreadyout_out, .hresp_out, .fault_flags_in, .usb_absent_in, .background_in,
  .span_check_in, .zero_check_in, .maintenance_in, .analog_out_overrange_in,
  .control_input_n_in, .status_out, .cal_mode_out, .irq_out);
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench of the status output mapper
// Assumes: zero-wait slave, one-cycle status latency
// Notes: a far-side model drives the control pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sreq = 0, zreq = 0, hready, hresp, irq;
  logic [1:0] htrans = 0, cal;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic [19:0] cnd = 0;
  logic [7:0] status, pins;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n, b;
  initial forever #5 clk = ~clk;
  sdom_ext_equip eq (.span_req_in(sreq), .zero_req_in(zreq), .pins_out(pins));
  sdom_mapper dut (.mclk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .fault_flags_in(cnd[10:0]), .usb_absent_in(cnd[11]), .background_in(cnd[12]),
    .span_check_in(cnd[13]), .zero_check_in(cnd[14]), .maintenance_in(cnd[16]),
    .analog_out_overrange_in(cnd[19:17]), .control_input_n_in(pins),
    .status_out(status), .cal_mode_out(cal), .irq_out(irq));
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic sel(input int o, input logic [4:0] c);
    wr(o < 4 ? 32'h0 : 32'h4, {27'h0, c} << (8 * (o % 4)));
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // timeout, far above the ~310 cycles used
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    xfer(1'b0, 32'h8, 32'h0, rv); chk("opol", rv, 32'hff);
    xfer(1'b0, 32'h0, 32'h0, rv); chk("osel", rv, 32'h0);
    xfer(1'b0, 32'h20, 32'h0, rv); chk("unmapped", rv, 32'h0);
    chk("status", {24'h0, status}, 32'h0);
    $display("test reset done");
    for (int c = 1; c <= 20; c++) begin
      n = c % 8;
      b = (c == 16) ? 10 : c - 1;
      sel(n, 5'(c));
      cnd <= 20'h1 << b;
      repeat (3) @(posedge clk);
      chk("hit", {24'h0, status}, 32'h1 << n);
      cnd <= 20'h0;
      repeat (3) @(posedge clk);
      chk("clear", {24'h0, status}, 32'h0);
      sel(n, 5'h0);
    end
    sel(7, 5'h10);
    for (int f = 0; f < 11; f++) begin
      cnd <= 20'h1 << f;
      repeat (3) @(posedge clk);
      chk("sysfault", {24'h0, status}, 32'h80);
    end
    cnd <= 20'hfffff;
    sel(7, 5'h0);
    sel(1, 5'h15);
    repeat (3) @(posedge clk);
    chk("disabled", {24'h0, status}, 32'h0);
    cnd <= 20'h0;
    sel(1, 5'h0);
    sel(0, 5'h1);
    wr(32'h8, 32'hfe);
    repeat (3) @(posedge clk);
    chk("pol idle", {24'h0, status}, 32'h1);
    cnd <= 20'h1;
    repeat (3) @(posedge clk);
    chk("pol act", {24'h0, status}, 32'h0);
    $display("test outputs done");
    wr(32'hc, 32'h9);
    sreq <= 1'b1;
    repeat (6) @(posedge clk);
    chk("span", {30'h0, cal}, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(32'h1c, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    xfer(1'b0, 32'h18, 32'h0, rv); chk("stat span", rv, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clr", {31'h0, irq}, 32'h0);
    zreq <= 1'b1;
    repeat (6) @(posedge clk);
    chk("zero", {30'h0, cal}, 32'h2);
    xfer(1'b0, 32'h18, 32'h0, rv); chk("stat zero", rv, 32'h2);
    xfer(1'b0, 32'h14, 32'h0, rv); chk("state", rv, 32'hc02);
    wr(32'h14, 32'h0);
    @(posedge clk);
    chk("cal write", {30'h0, cal}, 32'h0);
    wr(32'h14, 32'h3);
    @(posedge clk);
    chk("cal bad code", {30'h0, cal}, 32'h0);
    wr(32'h10, 32'h1);
    sreq <= 1'b0;
    repeat (6) @(posedge clk);
    chk("span high", {30'h0, cal}, 32'h1);
    xfer(1'b0, 32'h18, 32'h0, rv); chk("stat high", rv, 32'h1);
    $display("test control done");
    end_sim();
  end
endmodule
`default_nettype wire
